// file: core/ersyn_pkg.sv
// Package for the error record status syndrome block.
// Assumes a 64-bit status word reached by a plain read/write port.
package ersyn_pkg;
    localparam int STATUS_W = 64;
    localparam int POS_VALID = 30;
    localparam int POS_UNCORR = 29;
    localparam int POS_MISC_VALID = 26;
    localparam int POS_CE_LO = 24;
    localparam int POS_DEFERRED = 23;
    localparam int POS_POISON = 22;
    localparam int POS_UET_LO = 20;
    localparam int POS_CRITICAL = 19;
    localparam int POS_IMPL_LO = 8;
    localparam logic [1:0] CE_NONE = 2'h0;
    localparam logic [1:0] CE_TRANSIENT = 2'h1;
    localparam logic [1:0] CE_GENERIC = 2'h2;
    localparam logic [1:0] CE_PERSISTENT = 2'h3;
    localparam logic [1:0] FIELD_ALL_ONES = 2'h3;
    localparam logic [1:0] FIELD_ALL_ZEROS = 2'h0;
    localparam logic [1:0] UET_UNCONTAINABLE = 2'h0;
    localparam logic [1:0] UET_UNRECOVERABLE = 2'h1;
    localparam logic [1:0] UET_LATENT_OR_RESTARTABLE = 2'h2;
    localparam logic [1:0] UET_SIGNALED_OR_RECOVERABLE = 2'h3;
    localparam logic RESET_FLAG = 1'h0;
    localparam logic [1:0] RESET_FIELD2 = 2'h0;
    localparam logic [7:0] RESET_IMPL = 8'h00;
    // Filler returned for fields whose content is architecturally unknown
    localparam logic [1:0] UNKNOWN_FIELD2 = 2'h0;
    localparam logic UNKNOWN_FLAG = 1'h0;
    localparam logic [7:0] IMPL_CODE_MAX = 8'h0f;
endpackage

// file: core/ersyn_status.sv
// Syndrome portion of one error record status register.
// Assumes detection logic and the register port run on sys_clk; cold reset is rst_b,
// error recovery reset is a synchronous pulse that leaves every field alone.
// How it works
// RULE1 - Misc-valid bit 26 reads one while misc registers hold extra error info
// RULE2 - Misc-valid is write-one-to-clear, cold reset zero, kept on recovery reset
// RULE3 - Without misc info support, bit 26 reads zero and ignores writes
// RULE4 - Corrected kind: none, transient, corrected, persistent encoded 00 to 11
// RULE5 - Without transient/persistent detection, corrected errors load kind 10
// RULE6 - Two-bit fields clear on all ones, hold on zeros, else unpredictable
// RULE7 - Corrected kind, deferred, critical read unknown when record-valid is zero
// RULE8 - Deferred bit 23 set when an error was deferred, if deferral supported
// RULE9 - Poison bit 22 set for uncorrected or deferred errors caused by poison
// RULE10 - Poison reads unknown unless valid and deferred or uncorrected; one clears
// RULE11 - Uncorrected type: uncontainable, unrecoverable, latent, signaled 00 to 11
// RULE12 - Uncorrected type reads unknown when valid or uncorrected flag is zero
// RULE13 - Critical bit 19 reads one once a critical condition is recorded
// RULE14 - Syndrome fields unknown on cold reset, kept on recovery reset
// RULE15 - Eight-bit implementation code; unsupported written values read unknown
// RULE16 - Software should write ones to nonzero multi-bit fields when clearing valid
// RULE17 - Misc registers must tell software which error and class each field is
// RULE18 - Record-valid bit 30 set on any recorded error, one clears, cold reset zero
// RULE19 - Uncorrected flag bit 29 set for errors neither corrected nor deferred
// RULE20 - Record-valid and syndrome fields update in the same cycle
`timescale 1ns/10ps
module ersyn_status #(
    parameter bit MISC_INFO_SUPPORTED = 1'b1,
    parameter bit DEFER_SUPPORTED = 1'b1,
    parameter bit CE_KIND_DETECT = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic recovery_reset,
    input wire logic wr_en,
    input wire logic [63:0] wr_data,
    input wire logic rec_en,
    input wire logic rec_corrected,
    input wire logic [1:0] rec_ce_kind,
    input wire logic rec_deferred,
    input wire logic rec_uncorrected,
    input wire logic rec_poison,
    input wire logic [1:0] rec_uet,
    input wire logic rec_critical,
    input wire logic rec_misc_info,
    input wire logic [7:0] rec_impl_code,
    output logic [63:0] status
);
    typedef struct packed {
        logic valid;
        logic uncorrected_flag;
        logic misc_info_valid;
        logic deferred_flag;
        logic poison_flag;
        logic critical_flag;
        logic [7:0] impl_error_code;
        logic [63:0] status;
    } ersyn_state_type;

    ersyn_state_type state;
    ersyn_state_type next_state;
    logic [1:0] ce_value;
    logic [1:0] uet_value;
    logic [1:0] ce_load_value;
    logic [1:0] wr_ce;
    logic [1:0] wr_uet;
    logic ce_load;
    logic uet_load;
    logic [1:0] ce_read;
    logic [1:0] uet_read;
    logic [63:0] next_status;
    logic [1:0] next_ce_value;
    logic [1:0] next_uet_value;

    assign wr_ce = wr_data[ersyn_pkg::POS_CE_LO +: 2];
    assign wr_uet = wr_data[ersyn_pkg::POS_UET_LO +: 2];
    // Same-cycle load with the valid bit keeps the syndrome coherent
    assign ce_load = rec_en && rec_corrected; // RULE20
    assign uet_load = rec_en && rec_uncorrected; // RULE20
    // Kinds are only kept if the node can tell them apart
    assign ce_load_value = CE_KIND_DETECT ? rec_ce_kind : ersyn_pkg::CE_GENERIC; // RULE4 RULE5

    ersyn_w1c_field u_ce (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wr_en(wr_en),
        .wr_data(wr_ce),
        .load(ce_load),
        .load_value(ce_load_value),
        .value(ce_value)
    );

    ersyn_w1c_field u_uet (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wr_en(wr_en),
        .wr_data(wr_uet),
        .load(uet_load),
        .load_value(rec_uet), // RULE11
        .value(uet_value)
    );

    always_comb begin
        next_state = state;
        // Writes: each flag is one-to-clear; recording in the same cycle wins
        if (wr_en) begin
            if (wr_data[ersyn_pkg::POS_VALID]) begin
                next_state.valid = 1'b0; // RULE18
            end
            if (wr_data[ersyn_pkg::POS_UNCORR]) begin
                next_state.uncorrected_flag = 1'b0; // RULE19
            end
            if (wr_data[ersyn_pkg::POS_MISC_VALID]) begin
                next_state.misc_info_valid = 1'b0; // RULE2
            end
            if (wr_data[ersyn_pkg::POS_DEFERRED]) begin
                next_state.deferred_flag = 1'b0; // RULE7
            end
            if (wr_data[ersyn_pkg::POS_POISON]) begin
                next_state.poison_flag = 1'b0; // RULE10
            end
            if (wr_data[ersyn_pkg::POS_CRITICAL]) begin
                next_state.critical_flag = 1'b0; // RULE7
            end
            // Unsupported codes are simply stored; the read-back is unpredictable anyway
            next_state.impl_error_code = wr_data[ersyn_pkg::POS_IMPL_LO +: 8]; // RULE15
        end
        if (rec_en) begin
            next_state.valid = 1'b1; // RULE18 RULE20
            if (rec_uncorrected && !(DEFER_SUPPORTED && rec_deferred)) begin
                next_state.uncorrected_flag = 1'b1; // RULE19
            end
            if (DEFER_SUPPORTED && rec_deferred) begin
                next_state.deferred_flag = 1'b1; // RULE8
            end
            // Poison only accompanies uncorrected or deferred errors
            if (rec_poison && (rec_uncorrected || (DEFER_SUPPORTED && rec_deferred))) begin
                next_state.poison_flag = 1'b1; // RULE9
            end
            if (rec_critical) begin
                next_state.critical_flag = 1'b1; // RULE13
            end
            if (MISC_INFO_SUPPORTED && rec_misc_info) begin
                next_state.misc_info_valid = 1'b1; // RULE1 RULE17
            end
            next_state.impl_error_code = rec_impl_code; // RULE15 RULE20
        end
        if (!MISC_INFO_SUPPORTED) begin
            next_state.misc_info_valid = 1'b0; // RULE3
        end
        // Mirror of the field submodules' next value, so status can be a plain flop
        next_ce_value = ce_value;
        if (wr_en && wr_ce == ersyn_pkg::FIELD_ALL_ONES) begin
            next_ce_value = ersyn_pkg::CE_NONE; // RULE6
        end
        if (ce_load) begin
            next_ce_value = ce_load_value;
        end
        next_uet_value = uet_value;
        if (wr_en && wr_uet == ersyn_pkg::FIELD_ALL_ONES) begin
            next_uet_value = ersyn_pkg::CE_NONE; // RULE6
        end
        if (uet_load) begin
            next_uet_value = rec_uet;
        end
        // Readback view from the state as it will stand after this edge
        next_status = '0;
        ce_read = ersyn_pkg::UNKNOWN_FIELD2;
        uet_read = ersyn_pkg::UNKNOWN_FIELD2;
        if (next_state.valid) begin
            ce_read = next_ce_value; // RULE7
            if (next_state.uncorrected_flag) begin
                uet_read = next_uet_value; // RULE12
            end
        end
        next_status[ersyn_pkg::POS_VALID] = next_state.valid;
        if (next_state.valid) begin
            next_status[ersyn_pkg::POS_UNCORR] = next_state.uncorrected_flag;
            next_status[ersyn_pkg::POS_DEFERRED] = next_state.deferred_flag; // RULE7
            next_status[ersyn_pkg::POS_CRITICAL] = next_state.critical_flag; // RULE7
            next_status[ersyn_pkg::POS_IMPL_LO +: 8] = next_state.impl_error_code;
            if (next_state.deferred_flag || next_state.uncorrected_flag) begin
                next_status[ersyn_pkg::POS_POISON] = next_state.poison_flag; // RULE10
            end
        end
        next_status[ersyn_pkg::POS_MISC_VALID] = next_state.misc_info_valid; // RULE1 RULE3
        next_status[ersyn_pkg::POS_CE_LO +: 2] = ce_read;
        next_status[ersyn_pkg::POS_UET_LO +: 2] = uet_read;
        next_state.status = next_status;
    end

    // Output straight from the state register
    assign status = state.status;

    // Cold reset only; recovery_reset is deliberately not a reset term
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '{valid: ersyn_pkg::RESET_FLAG, // RULE2 RULE14 RULE18
                       uncorrected_flag: ersyn_pkg::RESET_FLAG,
                       misc_info_valid: ersyn_pkg::RESET_FLAG,
                       deferred_flag: ersyn_pkg::RESET_FLAG,
                       poison_flag: ersyn_pkg::RESET_FLAG,
                       critical_flag: ersyn_pkg::RESET_FLAG,
                       impl_error_code: ersyn_pkg::RESET_IMPL,
                       status: '0};
        end else begin
            state <= next_state; // RULE14
        end
    end
endmodule

// file: core/ersyn_w1c_field.sv
// Two-bit write-ones-to-clear field with hardware load; load wins over clear.
// Assumes write strobes come from logic on sys_clk.
`timescale 1ns/10ps
module ersyn_w1c_field (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [1:0] wr_data,
    input wire logic load,
    input wire logic [1:0] load_value,
    output logic [1:0] value
);
    typedef struct packed {
        logic [1:0] value;
    } ersyn_fld_state_type;

    ersyn_fld_state_type state;
    ersyn_fld_state_type next_state;

    always_comb begin
        next_state = state;
        if (wr_en && wr_data == ersyn_pkg::FIELD_ALL_ONES) begin
            next_state.value = ersyn_pkg::CE_NONE; // RULE6
        end else if (wr_en && wr_data != ersyn_pkg::FIELD_ALL_ZEROS) begin
            // Any mixed pattern: the stored value is unpredictable; keep it
            next_state.value = state.value; // RULE6
        end
        if (load) begin
            next_state.value = load_value;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '{value: ersyn_pkg::RESET_FIELD2};
        end else begin
            state <= next_state;
        end
    end

    assign value = state.value;
endmodule

// file: test/ersyn_status_props.sv
// Checker for the error record status syndrome block.
// Assumes it is bound to ersyn_status and sees only that module's ports.
`timescale 1ns/10ps
module ersyn_status_props (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [63:0] wr_data,
    input wire logic rec_en,
    input wire logic rec_corrected,
    input wire logic [1:0] rec_ce_kind,
    input wire logic rec_deferred,
    input wire logic rec_uncorrected,
    input wire logic rec_poison,
    input wire logic [1:0] rec_uet,
    input wire logic rec_critical,
    input wire logic [7:0] rec_impl_code,
    input wire logic [63:0] status
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // Field loads are only checked into an empty record, where no merge policy applies
    a_valid_set: assert property (rec_en |=> status[30]) else $error("valid not set");
    a_uncorr_set: assert property (rec_en && rec_uncorrected && !rec_deferred |=> status[29])
        else $error("uncorrected flag not set");
    a_valid_clear: assert property (wr_en && wr_data[30] && !rec_en |=> !status[30])
        else $error("valid not cleared");
    a_valid_hold: assert property (!rec_en && !(wr_en && wr_data[30]) |=> $stable(status[30]))
        else $error("valid changed");
    a_reserved_zero: assert property ((status & 64'hffff_ffff_9807_00ff) == 64'h0)
        else $error("reserved bits set");
    a_kind_gated: assert property (!status[30] |-> status[25:24] == 2'h0)
        else $error("kind not gated");
    a_type_gated: assert property (!status[29] |-> status[21:20] == 2'h0)
        else $error("type not gated");
    a_type_load: assert property (rec_en && !status[30] && rec_uncorrected && !rec_deferred
        |=> status[21:20] == $past(rec_uet)) else $error("type not loaded");
    a_kind_load: assert property (rec_en && !status[30] && rec_corrected
        |=> status[25:24] == $past(rec_ce_kind)) else $error("kind not loaded");
    a_poison_load: assert property (rec_en && !status[30] && rec_poison && rec_uncorrected
        |=> status[22]) else $error("poison not set");
    a_misc_clear: assert property (wr_en && wr_data[26] && !rec_en |=> !status[26])
        else $error("misc valid not cleared");
    a_crit_set: assert property (rec_en && rec_critical |=> status[19])
        else $error("critical not set");
    a_code_load: assert property (rec_en && !status[30] |=> status[15:8] == $past(rec_impl_code))
        else $error("code not loaded");
    c_uncorr: cover property (rec_en && rec_uncorrected);
    c_corr: cover property (rec_en && rec_corrected);
    c_clear: cover property (wr_en && wr_data[30] && status[30]);
endmodule

bind ersyn_status ersyn_status_props u_props (.sys_clk, .rst_b, .wr_en, .wr_data, .rec_en,
    .rec_corrected, .rec_ce_kind, .rec_deferred, .rec_uncorrected, .rec_poison, .rec_uet,
    .rec_critical, .rec_impl_code, .status);

// file: test/testbench.sv
// Testbench for the error record status syndrome block.
// Assumes the block's record and write ports are the only access path.
`timescale 1ns/10ps
module testbench;
    logic sys_clk, rst_b, recovery_reset, wr_en, rec_en, rec_corrected, rec_deferred;
    logic rec_uncorrected, rec_poison, rec_critical, rec_misc_info;
    logic [1:0] rec_ce_kind, rec_uet;
    logic [7:0] rec_impl_code;
    logic [63:0] wr_data, status;
    int n_fail = 0, cmp_count = 0, cycles = 0;
    localparam logic [63:0] CLR_ALL = 64'h0000_0000_67f8_0000;
    ersyn_status u_dut (.sys_clk, .rst_b, .recovery_reset, .wr_en, .wr_data, .rec_en,
        .rec_corrected, .rec_ce_kind, .rec_deferred, .rec_uncorrected, .rec_poison, .rec_uet,
        .rec_critical, .rec_misc_info, .rec_impl_code, .status);
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 1000) begin
            n_fail++;
            results();
        end
    end
    task results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] want, input string what);
        cmp_count++;
        if (seen !== want) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, want, seen);
        end
    endtask
    // Inputs move 1 ns after an edge; status is settled when the task returns
    task step(input logic r, input logic w);
        rec_en = r;
        wr_en = w;
        @(posedge sys_clk);
        #1;
        rec_en = 1'b0;
        wr_en = 1'b0;
    endtask
    task fields(input logic c, d, u, p, ci, mi, input logic [1:0] k, t, input logic [7:0] ic);
        {rec_corrected, rec_deferred, rec_uncorrected, rec_poison} = {c, d, u, p};
        {rec_critical, rec_misc_info, rec_ce_kind, rec_uet, rec_impl_code} = {ci, mi, k, t, ic};
    endtask
    task clear_all();
        wr_data = CLR_ALL;
        step(1'b0, 1'b1);
        chk({16'h0, status[31:16]}, 32'h0, "cleared");
    endtask
    initial begin
        {rst_b, recovery_reset, wr_en, rec_en} = 4'h0;
        wr_data = 64'h0;
        fields(0, 0, 0, 0, 0, 0, 2'h0, 2'h0, 8'h00);
        repeat (5) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        chk(status[31:0], 32'h0, "cold reset");
        chk(status[63:32], 32'h0, "upper half");
        $display("test reset done");
        for (int t = 0; t < 4; t++) begin
            fields(0, 0, 1, 1, 1, 1, 2'h0, t[1:0], 8'ha0 + 8'(t));
            step(1'b1, 1'b0);
            chk(status[31:0], 32'h6448_a000 | (32'(t) << 20) | (32'(t) << 8), "uet");
            clear_all();
        end
        $display("test uncorrected done");
        for (int k = 1; k < 4; k++) begin
            fields(1, 0, 0, 0, 0, 0, k[1:0], 2'h0, 8'h00);
            step(1'b1, 1'b0);
            chk({16'h0, status[31:16]}, 32'h4000 | (32'(k) << 8), "kind");
            wr_data = 64'h0;
            step(1'b0, 1'b1);
            chk({16'h0, status[31:16]}, 32'h4000 | (32'(k) << 8), "zero write");
            wr_data = 64'h0300_0000;
            step(1'b0, 1'b1);
            chk({16'h0, status[31:16]}, 32'h4000, "ones write");
            clear_all();
        end
        $display("test corrected done");
        fields(0, 1, 0, 1, 0, 0, 2'h0, 2'h0, 8'h00);
        step(1'b1, 1'b0);
        recovery_reset = 1'b1;
        step(1'b0, 1'b0);
        recovery_reset = 1'b0;
        chk({16'h0, status[31:16]}, 32'h40c0, "deferred kept");
        clear_all();
        $display("test deferred done");
        fields(0, 0, 1, 0, 0, 0, 2'h0, 2'h3, 8'h00);
        wr_data = CLR_ALL;
        step(1'b1, 1'b1);
        chk({16'h0, status[31:16]}, 32'h6030, "record beats clear");
        wr_data = 64'h4000_0000;
        step(1'b0, 1'b1);
        chk({16'h0, status[31:16] & 16'h4330}, 32'h0, "gated after clear");
        clear_all();
        $display("test ordering done");
        results();
    end
endmodule
